/* File: dma_chan_pkg.sv */
// shared constants and types for the dma channel control and event block
package dma_chan_pkg;
    localparam logic [11:0] off_ctrl      = 12'h000;
    localparam logic [11:0] off_econ      = 12'h004;
    localparam logic [11:0] off_status    = 12'h008;
    localparam logic [11:0] off_mask      = 12'h00c;
    localparam int          bit_chain_dir = 8;
    localparam int          bit_chan_on   = 7;
    localparam int          bit_accept    = 6;
    localparam int          bit_chain_ok  = 5;
    localparam int          bit_rearm     = 4;
    localparam int          bit_ext_addr  = 3;
    localparam int          bit_ev_seen   = 2;
    localparam int          bit_force     = 7;
    localparam int          bit_abort     = 6;
    localparam int          bit_pat_en    = 5;
    localparam int          bit_start_en  = 4;
    localparam int          bit_abort_en  = 3;
    localparam logic [7:0]  irq_num_reset = 8'hff;
    localparam int          lsb_abort_irq = 16;
    localparam int          lsb_start_irq = 8;
    localparam int          n_irq         = 256;
    // status bits: 0 start taken, 1 abort taken, 2 abort taken from a pending irq event, 3 chain enable
    localparam int          n_stat        = 4;

    typedef struct packed {
        logic chain_dir;
        logic chan_on;
        logic accept;
        logic chain_ok;
        logic rearm;
        logic ext_addr;
    } ctrl_s;

    typedef struct packed {
        logic [7:0] abort_irq;
        logic [7:0] start_irq;
        logic       pat_en;
        logic       start_en;
        logic       abort_en;
    } econ_s;
endpackage

/* File: dma_chan_ctrl.sv */
// dma channel control, chaining and irq-triggered start/abort events
//
// Functional notes
// - unused control bits read as zero
// - direction bit picks lower or higher neighbour
// - direction bit matters only when chaining
// - channel on bit enables the channel
// - accept events while off, else ignore
// - chain allow enables on neighbour completion
// - without re-arm, completion clears channel on
// - extended addressing bit drives its output
// - event seen flag shows detected event
// - abort irq number selects abort, resets ones
// - start irq number selects start, resets ones
// - force bit starts transfer, reads zero
// - abort bit aborts transfer, reads zero
// - pattern match aborts and clears on
// - abort irq acts only when enabled
`timescale 1ns/1ps
module dma_chan_ctrl (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [255:0] irq_in,
    input  wire logic         lower_done,
    input  wire logic         higher_done,
    input  wire logic         block_done,
    input  wire logic         pattern_match,
    output logic              xfer_start,
    output logic              xfer_abort,
    output logic              chan_enabled,
    output logic              ext_addr,
    output logic              irq
);
    dma_chan_pkg::ctrl_s      ctrl_q;
    dma_chan_pkg::econ_s      econ_q;
    logic [dma_chan_pkg::n_stat-1:0] stat_q;
    logic [dma_chan_pkg::n_stat-1:0] mask_q;
    logic [255:0]             irq_s1_q;
    logic [255:0]             irq_s2_q;
    logic                     start_pend_q;
    logic                     abort_pend_q;
    logic                     ev_seen_q;
    logic                     wr;
    logic                     rd_ok;
    logic                     start_ev;
    logic                     abort_ev;
    logic                     chain_ev;
    logic                     accept_now;
    logic                     do_start;
    logic                     do_abort;
    logic                     pat_abort;
    logic [dma_chan_pkg::n_stat-1:0] stat_set;
    logic [31:0]              rd_val;

    function automatic logic known_addr(input logic [11:0] a);
        return (a == dma_chan_pkg::off_ctrl) || (a == dma_chan_pkg::off_econ) ||
               (a == dma_chan_pkg::off_status) || (a == dma_chan_pkg::off_mask);
    endfunction

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite && ce;
    assign rd_ok   = known_addr(paddr);
    assign pslverr = psel && penable && !rd_ok;

    // irq lines come from other logic that may be unrelated in phase, so they are synchronised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_s1_q <= '0;
            irq_s2_q <= '0;
        end else if (ce) begin
            irq_s1_q <= irq_in;
            irq_s2_q <= irq_s1_q;
        end
    end

    assign start_ev   = econ_q.start_en && irq_s2_q[econ_q.start_irq];
    assign abort_ev   = econ_q.abort_en && irq_s2_q[econ_q.abort_irq];
    assign pat_abort  = econ_q.pat_en && pattern_match && ctrl_q.chan_on;
    assign chain_ev   = ctrl_q.chain_ok && (ctrl_q.chain_dir ? lower_done : higher_done);
    assign accept_now = ctrl_q.chan_on || ctrl_q.accept;

    // software force and abort bypass the accept gate, they are direct commands
    assign do_start = ctrl_q.chan_on && (start_pend_q ||
                      (wr && paddr == dma_chan_pkg::off_econ && pwdata[dma_chan_pkg::bit_force]));
    assign do_abort = ctrl_q.chan_on && (abort_pend_q ||
                      (wr && paddr == dma_chan_pkg::off_econ && pwdata[dma_chan_pkg::bit_abort]))
                      || pat_abort;

    // pending events; set beats the consume so nothing is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pend_q <= 1'b0;
            abort_pend_q <= 1'b0;
        end else if (ce) begin
            if (ctrl_q.chan_on) begin
                start_pend_q <= 1'b0;
                abort_pend_q <= 1'b0;
            end
            if (start_ev && accept_now)
                start_pend_q <= 1'b1;
            if (abort_ev && accept_now)
                abort_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_seen_q <= 1'b0;
        end else if (ce) begin
            if (do_start || do_abort)
                ev_seen_q <= 1'b0;
            if ((start_ev || abort_ev) && accept_now)
                ev_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else if (ce) begin
            if (wr && paddr == dma_chan_pkg::off_ctrl) begin
                ctrl_q.chain_dir <= pwdata[dma_chan_pkg::bit_chain_dir];
                ctrl_q.chan_on   <= pwdata[dma_chan_pkg::bit_chan_on];
                ctrl_q.accept    <= pwdata[dma_chan_pkg::bit_accept];
                ctrl_q.chain_ok  <= pwdata[dma_chan_pkg::bit_chain_ok];
                ctrl_q.rearm     <= pwdata[dma_chan_pkg::bit_rearm];
                ctrl_q.ext_addr  <= pwdata[dma_chan_pkg::bit_ext_addr];
            end
            if ((block_done && !ctrl_q.rearm) || pat_abort)
                ctrl_q.chan_on <= 1'b0;
            if (chain_ev)
                ctrl_q.chan_on <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            econ_q.abort_irq <= dma_chan_pkg::irq_num_reset;
            econ_q.start_irq <= dma_chan_pkg::irq_num_reset;
            econ_q.pat_en    <= 1'b0;
            econ_q.start_en  <= 1'b0;
            econ_q.abort_en  <= 1'b0;
        end else if (ce && wr && paddr == dma_chan_pkg::off_econ) begin
            econ_q.abort_irq <= pwdata[dma_chan_pkg::lsb_abort_irq +: 8];
            econ_q.start_irq <= pwdata[dma_chan_pkg::lsb_start_irq +: 8];
            econ_q.pat_en    <= pwdata[dma_chan_pkg::bit_pat_en];
            econ_q.start_en  <= pwdata[dma_chan_pkg::bit_start_en];
            econ_q.abort_en  <= pwdata[dma_chan_pkg::bit_abort_en];
        end
    end

    // chain enable is reported too, so software can tell a neighbour woke the channel
    assign stat_set = {chain_ev, do_abort && abort_pend_q, do_abort, do_start};

    // sticky status, write one to clear, a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            mask_q <= '0;
        end else if (ce) begin
            if (wr && paddr == dma_chan_pkg::off_mask)
                mask_q <= pwdata[dma_chan_pkg::n_stat-1:0];
            stat_q <= (stat_q & ~((wr && paddr == dma_chan_pkg::off_status) ?
                       pwdata[dma_chan_pkg::n_stat-1:0] : '0)) | stat_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_start <= 1'b0;
            xfer_abort <= 1'b0;
        end else if (ce) begin
            xfer_start <= do_start && !do_abort;
            xfer_abort <= do_abort;
        end
    end

    assign chan_enabled = ctrl_q.chan_on;
    assign ext_addr     = ctrl_q.ext_addr;
    assign irq          = |(stat_q & mask_q);

    // read mux; write-only command bits and unmapped bits stay zero
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            dma_chan_pkg::off_ctrl: begin
                rd_val[dma_chan_pkg::bit_chain_dir] = ctrl_q.chain_dir;
                rd_val[dma_chan_pkg::bit_chan_on]   = ctrl_q.chan_on;
                rd_val[dma_chan_pkg::bit_accept]    = ctrl_q.accept;
                rd_val[dma_chan_pkg::bit_chain_ok]  = ctrl_q.chain_ok;
                rd_val[dma_chan_pkg::bit_rearm]     = ctrl_q.rearm;
                rd_val[dma_chan_pkg::bit_ext_addr]  = ctrl_q.ext_addr;
                rd_val[dma_chan_pkg::bit_ev_seen]   = ev_seen_q;
            end
            dma_chan_pkg::off_econ: begin
                rd_val[dma_chan_pkg::lsb_abort_irq +: 8] = econ_q.abort_irq;
                rd_val[dma_chan_pkg::lsb_start_irq +: 8] = econ_q.start_irq;
                rd_val[dma_chan_pkg::bit_pat_en]   = econ_q.pat_en;
                rd_val[dma_chan_pkg::bit_start_en] = econ_q.start_en;
                rd_val[dma_chan_pkg::bit_abort_en] = econ_q.abort_en;
            end
            dma_chan_pkg::off_status: rd_val[dma_chan_pkg::n_stat-1:0] = stat_q;
            dma_chan_pkg::off_mask:   rd_val[dma_chan_pkg::n_stat-1:0] = mask_q;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // read data is captured in the setup phase and stands through the access phase;
    // a register that changes during the access shows on the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rd_val;
        end
    end

    // an irq event passes the pending flop before it reaches the transfer outputs
    sequence s_start_caught;
        ce && start_ev && ctrl_q.chan_on;
    endsequence
    sequence s_abort_caught;
        ce && abort_ev && ctrl_q.chan_on;
    endsequence
    sequence s_sw_force;
        ce && wr && paddr == dma_chan_pkg::off_econ && pwdata[dma_chan_pkg::bit_force];
    endsequence
    sequence s_sw_abort;
        ce && wr && paddr == dma_chan_pkg::off_econ && pwdata[dma_chan_pkg::bit_abort];
    endsequence

    a_rearm_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && block_done && !ctrl_q.rearm && !chain_ev |=> !ctrl_q.chan_on)
        else $error("channel stayed on after completion without re-arm");
    a_chain_on: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ctrl_q.chain_ok && ctrl_q.chain_dir && lower_done |=> ctrl_q.chan_on)
        else $error("chain from lower neighbour did not enable channel");
    a_no_chain: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !ctrl_q.chain_ok && !ctrl_q.chan_on && !wr |=> !ctrl_q.chan_on)
        else $error("channel enabled without chaining");
    a_pat_abort: assert property (@(posedge pclk) disable iff (!presetn)
        ce && pat_abort && !chain_ev |=> xfer_abort && !ctrl_q.chan_on)
        else $error("pattern match did not abort");
    a_ignore_off: assert property (@(posedge pclk) disable iff (!presetn)
        ce && start_ev && !ctrl_q.chan_on && !ctrl_q.accept && !start_pend_q |=> !start_pend_q)
        else $error("event registered while off and not accepted");
    a_accept_off: assert property (@(posedge pclk) disable iff (!presetn)
        ce && start_ev && ctrl_q.accept && !ctrl_q.chan_on |=> start_pend_q)
        else $error("event accepted while off was not held pending");
    a_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_start |-> $past(ctrl_q.chan_on))
        else $error("start while channel off");
    a_pend_start: assert property (@(posedge pclk) disable iff (!presetn)
        ce && start_pend_q && ctrl_q.chan_on && !do_abort |=> xfer_start)
        else $error("pending start not taken");
    a_irq_pend: assert property (@(posedge pclk) disable iff (!presetn)
        s_start_caught |=> start_pend_q)
        else $error("selected start irq not held pending");
    a_irq_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_start_caught ##1 (ce && ctrl_q.chan_on && !do_abort) |=> xfer_start)
        else $error("selected start irq did not start a transfer");
    a_irq_abort: assert property (@(posedge pclk) disable iff (!presetn)
        s_abort_caught ##1 (ce && ctrl_q.chan_on) |=> xfer_abort && stat_q[2])
        else $error("selected abort irq did not abort and flag");
    a_force_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_sw_force ##0 (ctrl_q.chan_on && !do_abort) |=> xfer_start)
        else $error("force write did not start a transfer");
    a_abort_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        s_sw_abort ##0 ctrl_q.chan_on |=> xfer_abort)
        else $error("abort write did not abort the transfer");
    a_ev_seen: assert property (@(posedge pclk) disable iff (!presetn)
        ce && (start_ev || abort_ev) && accept_now |=> ev_seen_q)
        else $error("accepted event not flagged as seen");
    a_chan_on_wr: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == dma_chan_pkg::off_ctrl && !chain_ev && !block_done && !pat_abort
        |=> chan_enabled == $past(pwdata[dma_chan_pkg::bit_chan_on])) else $error("channel on bit not taken");
    a_ext_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && paddr == dma_chan_pkg::off_ctrl |=> ext_addr == $past(pwdata[dma_chan_pkg::bit_ext_addr]))
        else $error("extended addressing output does not follow its bit");

    // irq number reset values, then the read side: the captured word is checked while the access stands
    a_reset_irqn: assert property (@(posedge pclk)
        $rose(presetn) |-> econ_q.abort_irq == dma_chan_pkg::irq_num_reset &&
                           econ_q.start_irq == dma_chan_pkg::irq_num_reset)
        else $error("irq numbers not all ones after reset");
    a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && $past(ce) && paddr == dma_chan_pkg::off_ctrl |->
        prdata[31:dma_chan_pkg::bit_chain_dir+1] == '0 && prdata[dma_chan_pkg::bit_ev_seen-1:0] == '0)
        else $error("unused control bits read as one");
    a_force_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && $past(ce) && paddr == dma_chan_pkg::off_econ |->
        !prdata[dma_chan_pkg::bit_force] && !prdata[dma_chan_pkg::bit_abort])
        else $error("force or abort bit read as one");
endmodule

/* File: irq_src.sv */
// model of the interrupt request sources feeding the channel
`timescale 1ns/1ps
module irq_src (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         go,
    input  wire logic [7:0]   num,
    output logic      [255:0] irq_in
);
    // one-cycle request; a released line idles low like an inactive source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_in <= '0;
        end else begin
            irq_in <= go ? (256'h1 << num) : '0;
        end
    end
endmodule

/* File: testbench.sv */
// self-checking bench for the dma channel control and event block
`timescale 1ns/1ps
module testbench;
    localparam logic [11:0] a0 = dma_chan_pkg::off_ctrl;
    localparam logic [11:0] a4 = dma_chan_pkg::off_econ;
    localparam logic [11:0] a8 = dma_chan_pkg::off_status;
    localparam logic [11:0] ac = dma_chan_pkg::off_mask;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic         lower_done = 1'b0, higher_done = 1'b0, block_done = 1'b0, pattern_match = 1'b0, ce = 1'b1;
    logic         pready, pslverr, xfer_start, xfer_abort, chan_enabled, ext_addr, irq, e, s, a;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0000_0000, prdata, r, m_ctrl, m_econ, m_stat;
    logic [255:0] irq_in;
    logic [7:0]   num = 8'h00, es, ea;
    logic [31:0]  cv [5] = '{32'h0000_0120, 32'h0000_0020, 32'h0000_0120, 32'h0000_0100, 32'h0000_0020};
    logic [3:0]   dv [5] = '{4'h8, 4'h4, 4'h4, 4'hc, 4'h8};
    logic         xv [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int           num_errors = 0, tests_run = 0;

    always #12.5 pclk = ~pclk;

    dma_chan_ctrl dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq_in, .lower_done, .higher_done, .block_done, .pattern_match,
        .xfer_start, .xfer_abort, .chan_enabled, .ext_addr, .irq);
    irq_src u_src (.pclk, .presetn, .go, .num, .irq_in);

    task final_report;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            num_errors++;
            final_report();
        end
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
        if (ad == a0) m_ctrl = (d & 32'h0000_01f8) | (m_ctrl & 32'h0000_0004);
        if (ad == a4) m_econ = d & 32'h00ff_ff38;
        if (ad == a8) m_stat = m_stat & ~d;
    endtask
    task rd(input logic [11:0] ad);
        apb(1'b0, ad, 32'h0000_0000);
        chk("rdata", ad == a0 ? m_ctrl : ad == a4 ? m_econ : ad == a8 ? m_stat : 32'h0000_0000, r);
        chk("pslverr", ad > ac, e);
    endtask
    // the first look is in the launching step, so a pulse born on that edge is not missed
    task watch;
        s = 1'b0;
        a = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i > 0) @(posedge pclk);
            #1;
            s = s | (xfer_start === 1'b1);
            a = a | (xfer_abort === 1'b1);
        end
    endtask
    task fire(input logic [7:0] n);
        @(posedge pclk);
        num <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        watch();
    endtask
    task pulse(input logic [3:0] p);
        @(posedge pclk);
        {lower_done, higher_done, block_done, pattern_match} <= p;
        @(posedge pclk);
        {lower_done, higher_done, block_done, pattern_match} <= 4'h0;
        watch();
    endtask
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    function automatic logic [31:0] ev(input logic [7:0] f);
        return {8'h00, ea, es, f};
    endfunction

    initial begin
        m_ctrl = 32'h0000_0000;
        m_econ = 32'h00ff_ff00;
        m_stat = 32'h0000_0000;
        void'($urandom(32'h5fa6));
        es = 8'($urandom_range(254, 0));
        ea = es + 8'h01;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(a0);
        rd(a4);
        rd(12'h010);
        wr(a0, 32'hffff_ffff);
        rd(a0);
        settle();
        chk("chan_enabled", 1, chan_enabled);
        chk("ext_addr", 1, ext_addr);
        wr(a0, 32'h0000_0090);
        settle();
        chk("ext_addr", 0, ext_addr);
        wr(a4, ev(8'h80));
        watch();
        chk("start", 1, s);
        rd(a4);
        wr(a4, ev(8'h40));
        watch();
        chk("abort", 1, a);
        wr(a4, ev(8'h10));
        fire(es);
        chk("start", 1, s);
        fire(ea);
        chk("abort", 0, a);
        chk("start", 0, s);
        wr(a4, ev(8'h08));
        fire(es);
        chk("start", 0, s);
        chk("abort", 0, a);
        fire(ea);
        chk("abort", 1, a);
        wr(a4, ev(8'h10));
        wr(a0, 32'h0000_0050);
        fire(es);
        chk("start", 0, s);
        m_ctrl[2] = 1'b1;
        rd(a0);
        wr(a0, 32'h0000_00d0);
        watch();
        chk("start", 1, s);
        m_ctrl[2] = 1'b0;
        rd(a0);
        wr(a0, 32'h0000_0010);
        fire(es);
        wr(a0, 32'h0000_0090);
        watch();
        chk("start", 0, s);
        pulse(4'h2);
        chk("chan_enabled", 1, chan_enabled);
        wr(a0, 32'h0000_0080);
        pulse(4'h2);
        chk("chan_enabled", 0, chan_enabled);
        m_ctrl[7] = 1'b0;
        rd(a0);
        for (int k = 0; k < 5; k++) begin
            wr(a0, cv[k]);
            pulse(dv[k]);
            chk("chain", xv[k], chan_enabled);
        end
        wr(a0, 32'h0000_0090);
        wr(a4, ev(8'h20));
        pulse(4'h1);
        chk("abort", 1, a);
        chk("chan_enabled", 0, chan_enabled);
        wr(a0, 32'h0000_0090);
        wr(a4, ev(8'h00));
        pulse(4'h1);
        chk("abort", 0, a);
        wr(a8, 32'h0000_000f);
        wr(ac, 32'h0000_0001);
        settle();
        chk("irq", 0, irq);
        wr(a4, ev(8'h80));
        settle();
        chk("irq", 1, irq);
        m_stat = 32'h0000_0001;
        rd(a8);
        wr(ac, 32'h0000_0000);
        settle();
        chk("irq", 0, irq);
        wr(ac, 32'h0000_0001);
        wr(a8, 32'h0000_0001);
        settle();
        chk("irq", 0, irq);
        rd(a8);
        ce <= 1'b0;
        apb(1'b1, a0, 32'h0000_0000);
        ce <= 1'b1;
        rd(a0);
        chk("chan_enabled", 1, chan_enabled);
        final_report();
    end
endmodule
